// ==== src/srv_status_out.sv ====
// Ready, trouble and home-completion status outputs with AHB-Lite registers.
// Summary of operation
// - Ready rises after servo-on accepted and drive prepared; low otherwise.
// - Trouble output drops on power loss or protective trip.
// - Without alarm, trouble output rises within 1.5 s of power-on.
// - Network alarm bit is always the inverse of the trouble pin.
// - Home completion rises when a home return finishes.
// - Absolute mode: servo-off, forced stop, reset or alarm clear home completion.
// - Either stroke-end limit off clears home completion.
// - Home completion stays low until a first home return.
// - Erase alarm or counter warning needs a new home return.
// - Enabling absolute mode needs a new home return.
// - Changing station direction selection clears home completion.
// - Home completion is low while a home return runs.
// - Otherwise, after one home return, home completion follows ready.
// - In indexer operation both manual pulse inputs are ignored.
// - Ready and home completion outputs are mirrored as network bits; trouble is sent inverted as the alarm bit.
// - Open forced stop cuts base drive and brakes; closing releases.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module srv_status_out
    import srv_pkg::*;
#(
    parameter int unsigned POWERON_CYCLES = SRV_POWERON_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Network requests
    input wire logic servo_on_request,
    input wire logic fault_reset_request,
    // Drive core state
    input wire logic drive_prepared,
    input wire logic alarm_active,
    input wire logic abs_pos_erase_alarm,
    input wire logic abs_counter_warning,
    input wire logic station_dir_select,
    input wire logic home_busy,
    input wire logic home_complete,
    // Connector inputs
    input wire logic forced_stop_in,
    input wire logic fwd_limit_in,
    input wire logic rev_limit_in,
    input wire logic manual_pulse_fwd,
    input wire logic manual_pulse_rev,
    // Connector outputs
    output logic ready_out,
    output logic trouble_out,
    output logic home_done_out,
    // Network remote outputs
    output logic ready_remote,
    output logic alarm_remote,
    output logic home_done_remote,
    // Power stage and pulse command
    output logic base_drive_en,
    output logic dyn_brake_on,
    output logic pulse_fwd_cmd,
    output logic pulse_rev_cmd,
    // Interrupt
    output logic irq
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [SRV_IN_N-1:0] pins, pins_s;

    assign pins[SRV_IN_ESTOP] = forced_stop_in;
    assign pins[SRV_IN_FWD] = fwd_limit_in;
    assign pins[SRV_IN_REV] = rev_limit_in;
    assign pins[SRV_IN_PFWD] = manual_pulse_fwd;
    assign pins[SRV_IN_PREV] = manual_pulse_rev;

    // Reset values 0 mean forced stop open and limits off, the safe side.
    for (genvar gi = 0; gi < SRV_IN_N; gi++) begin : g_sync
        srv_sync #(.RST_VAL(SRV_IN_RST[gi])) u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin(pins[gi]),
            .level(pins_s[gi])
        );
    end

    // ****************************************************************
    // Power-on timer and emergency stop
    // ****************************************************************
    logic [SRV_PWR_CNT_W-1:0] pwr_cnt_r;
    logic pwr_done_r, estop_r;
    logic [SRV_CTRL_W-1:0] ctrl_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_cnt_r <= '0;
            pwr_done_r <= 1'b0;
        end else if (!pwr_done_r) begin
            pwr_cnt_r <= pwr_cnt_r + 1'b1;
            if (pwr_cnt_r == SRV_PWR_CNT_W'(POWERON_CYCLES - 2)) begin
                pwr_done_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            estop_r <= 1'b1;
        end else begin
            estop_r <= !pins_s[SRV_IN_ESTOP];
        end
    end

    // ****************************************************************
    // Ready, trouble and power stage
    // ****************************************************************
    logic ready_nxt, trouble_nxt;

    assign ready_nxt = servo_on_request && drive_prepared && pwr_done_r
        && !estop_r && !alarm_active;
    // Trip or no power drops trouble.
    assign trouble_nxt = pwr_done_r && !alarm_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_out <= 1'b0;
            ready_remote <= 1'b0;
            trouble_out <= 1'b0;
            alarm_remote <= 1'b1;
        end else begin
            ready_out <= ready_nxt;
            ready_remote <= ready_nxt;
            trouble_out <= trouble_nxt;
            alarm_remote <= !trouble_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_drive_en <= 1'b0;
            dyn_brake_on <= 1'b1;
        end else begin
            base_drive_en <= ready_nxt;
            dyn_brake_on <= estop_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_fwd_cmd <= 1'b0;
            pulse_rev_cmd <= 1'b0;
        end else begin
            pulse_fwd_cmd <= pins_s[SRV_IN_PFWD] && !ctrl_r[SRV_CTRL_IDX];
            pulse_rev_cmd <= pins_s[SRV_IN_PREV] && !ctrl_r[SRV_CTRL_IDX];
        end
    end

    // ****************************************************************
    // Home position return completion
    // ****************************************************************
    logic home_seen_r, abs_q_r, station_q_r, abs_rise, station_chg;
    logic seen_clr, abs_clr, home_clr, home_nxt;

    assign abs_rise = ctrl_r[SRV_CTRL_ABS] && !abs_q_r;
    assign station_chg = station_dir_select != station_q_r;
    // Events that demand a new home return.
    assign seen_clr = abs_pos_erase_alarm || abs_counter_warning || abs_rise || station_chg;
    assign abs_clr = ctrl_r[SRV_CTRL_ABS] && (!servo_on_request || estop_r
        || fault_reset_request || alarm_active);
    assign home_clr = abs_clr || seen_clr || home_busy
        || !pins_s[SRV_IN_FWD] || !pins_s[SRV_IN_REV];
    assign home_nxt = home_seen_r && !home_clr && ready_nxt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abs_q_r <= 1'b0;
            station_q_r <= 1'b0;
        end else begin
            abs_q_r <= ctrl_r[SRV_CTRL_ABS];
            station_q_r <= station_dir_select;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_seen_r <= 1'b0;
        end else if (home_complete) begin
            home_seen_r <= 1'b1;
        end else if (seen_clr) begin
            home_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_done_out <= 1'b0;
            home_done_remote <= 1'b0;
        end else begin
            home_done_out <= home_nxt;
            home_done_remote <= home_nxt;
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    // Zero wait states; reads are latched in the address phase, so a read
    // right after a write to the same word returns the old value.
    logic dp_wr_r, ap_act;
    logic [SRV_ADDR_W-1:0] dp_addr_r;
    logic [SRV_IRQ_W-1:0] irq_en_r, irq_stat_r, irq_clr, irq_ev, irq_stat_nxt;
    logic [SRV_STAT_W-1:0] status;
    logic [31:0] rd_nxt;

    assign ap_act = hsel && htrans[SRV_HTRANS_ACT] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= '0;
        end else begin
            dp_wr_r <= ap_act && hwrite;
            dp_addr_r <= haddr[SRV_ADDR_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= SRV_CTRL_RST;
            irq_en_r <= SRV_IRQ_RST;
        end else if (dp_wr_r) begin
            if (dp_addr_r == SRV_OFF_CTRL) begin
                ctrl_r <= hwdata[SRV_CTRL_W-1:0];
            end
            if (dp_addr_r == SRV_OFF_IRQ_EN) begin
                irq_en_r <= hwdata[SRV_IRQ_W-1:0];
            end
        end
    end

    assign status = {pwr_done_r, estop_r, home_seen_r, home_done_out, trouble_out, ready_out};

    always_comb begin
        rd_nxt = SRV_ZERO_WORD;
        case (haddr[SRV_ADDR_W-1:0])
            SRV_OFF_CTRL: rd_nxt[SRV_CTRL_W-1:0] = ctrl_r;
            SRV_OFF_STATUS: rd_nxt[SRV_STAT_W-1:0] = status;
            SRV_OFF_IRQ_STAT: rd_nxt[SRV_IRQ_W-1:0] = irq_stat_r;
            SRV_OFF_IRQ_EN: rd_nxt[SRV_IRQ_W-1:0] = irq_en_r;
            default: rd_nxt = SRV_ZERO_WORD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= SRV_ZERO_WORD;
            hreadyout <= 1'b1;
            hresp <= SRV_HRESP_OKAY;
        end else begin
            hrdata <= (ap_act && !hwrite) ? rd_nxt : SRV_ZERO_WORD;
            hreadyout <= 1'b1;
            hresp <= SRV_HRESP_OKAY;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign irq_ev[SRV_EV_READY] = ready_nxt && !ready_out;
    assign irq_ev[SRV_EV_FAULT] = !trouble_nxt && trouble_out;
    assign irq_ev[SRV_EV_HOME] = home_nxt && !home_done_out;
    assign irq_ev[SRV_EV_ESTOP] = !pins_s[SRV_IN_ESTOP] && !estop_r;
    assign irq_clr = (dp_wr_r && dp_addr_r == SRV_OFF_IRQ_CLR) ? hwdata[SRV_IRQ_W-1:0] : '0;
    // A new event outranks a clear written in the same cycle.
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= SRV_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_cause:
        assert property (!servo_on_request || !drive_prepared |=> !ready_out)
        else $error("ready high without servo-on and prepared drive");
    a_trouble_trip:
        assert property (alarm_active || !pwr_done_r |=> !trouble_out)
        else $error("trouble output high during trip or before power good");
    a_trouble_rise:
        assert property ($rose(pwr_done_r) && !alarm_active |=> trouble_out)
        else $error("trouble output late after power-on");
    a_alarm_polar:
        assert property (alarm_remote == !trouble_out)
        else $error("network alarm bit not inverse of trouble pin");
    a_home_abs:
        assert property (abs_clr |=> !home_done_out)
        else $error("home completion kept in absolute mode after clear cause");
    a_home_limit:
        assert property (!pins_s[SRV_IN_FWD] || !pins_s[SRV_IN_REV] |=> !home_done_out)
        else $error("home completion high with a stroke limit off");
    a_home_first:
        assert property (!home_seen_r |=> !home_done_out)
        else $error("home completion before any home return");
    a_seen_lost:
        assert property ((abs_pos_erase_alarm || abs_counter_warning) && !home_complete
            |=> !home_seen_r ##1 !home_done_out)
        else $error("home record survived erase alarm or counter warning");
    a_abs_enable:
        assert property ($rose(ctrl_r[SRV_CTRL_ABS]) && !home_complete |=> !home_seen_r)
        else $error("home record survived absolute mode enable");
    a_station_chg:
        assert property (station_chg |=> !home_done_out)
        else $error("home completion kept after station selection change");
    a_home_busy:
        assert property (home_busy |=> !home_done_out)
        else $error("home completion high during home return");
    a_home_follow:
        assert property (home_seen_r && !home_clr |=> home_done_out == ready_out)
        else $error("home completion not following ready");
    a_pulse_ignore:
        assert property (ctrl_r[SRV_CTRL_IDX] |=> !pulse_fwd_cmd && !pulse_rev_cmd)
        else $error("manual pulse passed in indexer operation");
    a_remote_copy:
        assert property (home_done_remote == home_done_out && ready_remote == ready_out)
        else $error("network bit differs from connector output");
    a_estop_cut:
        assert property (!pins_s[SRV_IN_ESTOP] |=> ##1 !base_drive_en && dyn_brake_on)
        else $error("base drive not cut on open forced stop");
    a_seen_set:
        assert property (home_complete |=> home_seen_r)
        else $error("completed home return not recorded");

    c_home_done: cover property ($rose(home_done_out));
    c_trouble_up: cover property ($rose(trouble_out));
    c_estop: cover property ($rose(dyn_brake_on) ##[1:20] $fell(dyn_brake_on));
    c_irq: cover property ($rose(irq));

endmodule

// ==== include/srv_pkg.sv ====
// Constants, register map and field layout of the servo status output block.
package srv_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned SRV_CLK_MHZ = 100;
    // Power-on to trouble-output-good, in seconds.
    localparam real SRV_POWERON_S = 1.5;
    // A longest time, so the cycle count rounds down.
    localparam int unsigned SRV_POWERON_CYC = $rtoi(SRV_POWERON_S * 1.0e6 * SRV_CLK_MHZ);
    localparam int SRV_PWR_CNT_W = 28;

    // ****************************************************************
    // Register map (byte offsets)
    // ****************************************************************
    localparam int SRV_ADDR_W = 8;
    localparam logic [7:0] SRV_OFF_CTRL = 8'h00;
    localparam logic [7:0] SRV_OFF_STATUS = 8'h04;
    localparam logic [7:0] SRV_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] SRV_OFF_IRQ_EN = 8'h0c;
    localparam logic [7:0] SRV_OFF_IRQ_CLR = 8'h10;

    // Control register fields.
    localparam int SRV_CTRL_W = 2;
    localparam int SRV_CTRL_ABS = 0;
    localparam int SRV_CTRL_IDX = 1;
    localparam logic [1:0] SRV_CTRL_RST = 2'h0;

    // Status register fields.
    localparam int SRV_STAT_W = 6;
    localparam int SRV_ST_READY = 0;
    localparam int SRV_ST_TROUBLE = 1;
    localparam int SRV_ST_HOME = 2;
    localparam int SRV_ST_SEEN = 3;
    localparam int SRV_ST_ESTOP = 4;
    localparam int SRV_ST_PWR = 5;

    // Interrupt status, enable and clear share this layout.
    localparam int SRV_IRQ_W = 4;
    localparam int SRV_EV_READY = 0;
    localparam int SRV_EV_FAULT = 1;
    localparam int SRV_EV_HOME = 2;
    localparam int SRV_EV_ESTOP = 3;
    localparam logic [3:0] SRV_IRQ_RST = 4'h0;

    // ****************************************************************
    // Pin inputs passing the synchroniser
    // ****************************************************************
    localparam int SRV_IN_N = 5;
    localparam int SRV_IN_ESTOP = 0;
    localparam int SRV_IN_FWD = 1;
    localparam int SRV_IN_REV = 2;
    localparam int SRV_IN_PFWD = 3;
    localparam int SRV_IN_PREV = 4;
    localparam logic [4:0] SRV_IN_RST = 5'h00;

    // ****************************************************************
    // AHB-Lite encodings
    // ****************************************************************
    localparam int SRV_HTRANS_ACT = 1;
    localparam logic SRV_HRESP_OKAY = 1'b0;
    localparam logic [31:0] SRV_ZERO_WORD = 32'h0000_0000;

endpackage

// ==== src/srv_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps

module srv_sync
    import srv_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once the second and third stages agree.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= RST_VAL;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end

endmodule

// ==== tb/srv_partner.sv ====
// Model of the drive core home-return sequencer facing the status block.
`timescale 1ns/1ps

module srv_partner #(
    parameter int BUSY_CYC = 6
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Start request and home-return progress
    input wire logic start,
    output logic home_busy,
    output logic home_complete
);
    // ****************************************************************
    // Home return sequence
    // ****************************************************************
    int cnt;

    // A start while busy is dropped, as a real sequencer would do.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            home_busy <= 1'b0;
            home_complete <= 1'b0;
        end else begin
            home_complete <= 1'b0;
            if (start && !home_busy) begin
                home_busy <= 1'b1;
                cnt <= BUSY_CYC;
            end else if (home_busy) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    home_busy <= 1'b0;
                    home_complete <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== tb/test_srv_status_out.sv ====
// Self-checking bench for the servo status output block.
`timescale 1ns/1ps

module test_srv_status_out;
    import srv_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, start;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic servo_on_request, fault_reset_request, drive_prepared, alarm_active;
    logic abs_pos_erase_alarm, abs_counter_warning, station_dir_select;
    logic home_busy, home_complete, forced_stop_in, fwd_limit_in, rev_limit_in;
    logic manual_pulse_fwd, manual_pulse_rev, ready_out, trouble_out, home_done_out;
    logic ready_remote, alarm_remote, home_done_remote, base_drive_en, dyn_brake_on;
    logic pulse_fwd_cmd, pulse_rev_cmd;
    int fail_count = 0;
    int checks_done = 0;

    srv_status_out #(.POWERON_CYCLES(20)) srv_status_out_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .servo_on_request(servo_on_request),
        .fault_reset_request(fault_reset_request), .drive_prepared(drive_prepared),
        .alarm_active(alarm_active), .abs_pos_erase_alarm(abs_pos_erase_alarm),
        .abs_counter_warning(abs_counter_warning), .station_dir_select(station_dir_select),
        .home_busy(home_busy), .home_complete(home_complete),
        .forced_stop_in(forced_stop_in), .fwd_limit_in(fwd_limit_in),
        .rev_limit_in(rev_limit_in), .manual_pulse_fwd(manual_pulse_fwd),
        .manual_pulse_rev(manual_pulse_rev), .ready_out(ready_out),
        .trouble_out(trouble_out), .home_done_out(home_done_out),
        .ready_remote(ready_remote), .alarm_remote(alarm_remote),
        .home_done_remote(home_done_remote), .base_drive_en(base_drive_en),
        .dyn_brake_on(dyn_brake_on), .pulse_fwd_cmd(pulse_fwd_cmd),
        .pulse_rev_cmd(pulse_rev_cmd), .irq(irq));

    srv_partner srv_partner_inst (.hclk(hclk), .hresetn(hresetn), .start(start),
        .home_busy(home_busy), .home_complete(home_complete));

    // ****************************************************************
    // Clock, sampling and tasks
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Values read right at an edge are those that stood before it.
    task tk(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'h2;
        do tk(1); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do tk(1); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task home();
        start <= 1'b1;
        tk(1);
        start <= 1'b0;
        tk(3);
        chk("home_busy_gate", 32'h0, home_done_out); // low while busy
        for (int i = 0; i < 20 && home_complete !== 1'b1; i++) tk(1);
        tk(3);
    endtask

    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        stop_test();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {hsel, hwrite, start, servo_on_request, fault_reset_request, alarm_active} = 6'h00;
        {abs_pos_erase_alarm, abs_counter_warning, station_dir_select} = 3'h0;
        {manual_pulse_fwd, manual_pulse_rev} = 2'h0;
        {drive_prepared, forced_stop_in, fwd_limit_in, rev_limit_in} = 4'hf;
        haddr = 32'h0;
        htrans = 2'h0;
        hsize = 3'h0;
        hwdata = 32'h0;
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        tk(10);
        chk("trouble_early", 32'h0, trouble_out); // timer still running
        tk(15);
        chk("trouble_on", 32'h1, trouble_out); // good once power-on time is over
        chk("alarm_remote", 32'h0, alarm_remote); // inverse of pin
        chk("ready_off", 32'h0, ready_out); // no servo-on
        bus(1'b0, SRV_OFF_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0, q);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, q);
        servo_on_request <= 1'b1;
        tk(3);
        chk("ready_on", 32'h1, ready_out); // servo-on accepted
        chk("ready_remote", 32'h1, ready_remote); // mirrored bit
        chk("home_first", 32'h0, home_done_out); // no home return yet
        bus(1'b0, SRV_OFF_IRQ_STAT, 32'h0);
        chk("irq_stat_ready", 32'h1, q & 32'h1);
        bus(1'b1, SRV_OFF_IRQ_EN, 32'h1);
        tk(2);
        chk("irq_set", 32'h1, irq);
        bus(1'b1, SRV_OFF_IRQ_CLR, 32'h1);
        tk(2);
        chk("irq_clr", 32'h0, irq);
        home();
        chk("home_done", 32'h1, home_done_out); // follows ready
        chk("home_remote", 32'h1, home_done_remote); // mirrored bit
        home(); // second return from done state
        fwd_limit_in <= 1'b0;
        tk(10);
        chk("home_limit", 32'h0, home_done_out); // limit off clears
        fwd_limit_in <= 1'b1;
        tk(10);
        chk("home_limit_back", 32'h1, home_done_out); // flag kept
        alarm_active <= 1'b1;
        tk(3);
        chk("trouble_alarm", 32'h0, trouble_out); // trip drops pin
        chk("alarm_remote_on", 32'h1, alarm_remote); // inverse of pin
        alarm_active <= 1'b0;
        tk(3);
        forced_stop_in <= 1'b0;
        tk(10);
        chk("brake_on", 32'h1, dyn_brake_on); // open stop brakes
        chk("base_off", 32'h0, base_drive_en); // base drive cut
        forced_stop_in <= 1'b1;
        tk(10);
        chk("brake_off", 32'h0, dyn_brake_on); // closing releases
        chk("base_on", 32'h1, base_drive_en); // base drive back
        bus(1'b1, SRV_OFF_CTRL, 32'h1);
        tk(3);
        chk("home_abs_rise", 32'h0, home_done_out); // enable needs new return
        home();
        chk("home_abs", 32'h1, home_done_out); // after new return
        fault_reset_request <= 1'b1;
        tk(3);
        chk("home_reset", 32'h0, home_done_out); // reset clears
        fault_reset_request <= 1'b0;
        tk(3);
        for (int i = 0; i < 2; i++) begin
            home();
            abs_pos_erase_alarm <= (i == 0);
            abs_counter_warning <= (i == 1);
            tk(1);
            {abs_pos_erase_alarm, abs_counter_warning} <= 2'h0;
            tk(5);
            chk("home_abs_loss", 32'h0, home_done_out); // stays low after event
        end
        home();
        station_dir_select <= 1'b1;
        tk(5);
        chk("home_station", 32'h0, home_done_out); // setting change clears
        bus(1'b1, SRV_OFF_CTRL, 32'h2);
        {manual_pulse_fwd, manual_pulse_rev} <= 2'h3;
        tk(10);
        chk("pulse_idx", 32'h0, {pulse_fwd_cmd, pulse_rev_cmd}); // pins ignored
        bus(1'b1, SRV_OFF_CTRL, 32'h0);
        tk(3);
        chk("pulse_pass", 32'h3, {pulse_fwd_cmd, pulse_rev_cmd}); // pins pass again
        stop_test();
    end
endmodule
